// File: ddr3_cmd_regs.svh
`ifndef DDR3_CMD_REGS_SVH
`define DDR3_CMD_REGS_SVH

// ****************************************************************
// address bit positions
// ****************************************************************
`define AP_BIT        4'd10
`define CHOP_BIT      4'd12
`define COL_MSB       4'd9

// ****************************************************************
// mode register fields and reset values
// ****************************************************************
`define MR_BL_LSB     4'd0
`define MR_BT_BIT     4'd3
`define MR_CL_LSB     4'd4
`define MR_AL_LSB     4'd3
`define MR0_RST       13'h0000
`define MR1_RST       13'h0000
`define BL_OTF        2'h1
`define BL_CHOP4      2'h2
`define AL_CL_M1      2'h1
`define AL_CL_M2      2'h2

// ****************************************************************
// timing counts: latency in link clock cycles, burst lengths in beats
// ****************************************************************
`define CL_BASE       5'h04
`define BEATS_BL8     4'h8
`define BEATS_BL4     4'h4

`endif

// File: ddr3_cmd_pkg.sv
package ddr3_cmd_pkg;

  // ****************************************************************
  // decoded commands
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACT = 3'h1,
    OP_PRE = 3'h2,
    OP_RD  = 3'h3,
    OP_WR  = 3'h4,
    OP_MRS = 3'h5,
    OP_REF = 3'h6
  } cmd_op_t;

  typedef struct packed {
    cmd_op_t     op;
    logic [2:0]  bank;
    logic [12:0] row;
    logic [9:0]  col;
    logic        auto_pre;
    logic        all_banks;
    logic        chop;
  } cmd_t;

  // ****************************************************************
  // power states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_PDOWN  = 3'b010,
    ST_SREF   = 3'b100
  } pwr_state_t;

endpackage

// File: ddr3_cmd_port.sv
`timescale 1ns/1ps
`include "ddr3_cmd_regs.svh"
// Overview of operation
// - commands and address taken only when clock rises and complement falls
// - read beats launched on both clock crossings, two per period
// - clock gate low suspends from next cycle, freezing read beats, bank state and burst; buffered commands still drain
// - clock gate low with all banks idle enters power-down or self-refresh
// - three-bit bank select picks one of eight banks per command
// - thirteen-bit row on activate, ten-bit column on read or write
// - mode register set loads operand from address inputs
// - auto-precharge flag on read or write closes bank after burst
// - precharge closes named bank, or all banks when flag high
// - burst length four or eight
// - sequential or interleaved burst ordering from mode register
// - additive latency zero, latency minus one or minus two
// - commands decoded only while chip select low
// - row strobe low, column high: activate or precharge by write select
// - row strobe high, column low: read or write by write select
// - burst chop input high means full burst, low means chopped
module ddr3_cmd_port (
  // system
  input  wire logic                 CLK_SYS,
  input  wire logic                 ARST_N,
  // memory pins
  input  wire logic                 CK,
  input  wire logic                 CLOCK_COMPLEMENT,
  input  wire logic                 CKE,
  input  wire logic                 CS_N,
  input  wire logic                 RAS_N,
  input  wire logic                 CAS_N,
  input  wire logic                 WE_N,
  input  wire logic [2:0]           BANK_SELECT,
  input  wire logic [12:0]          ROW_COL_ADDRESS,
  // decoded command stream
  output logic                      CMD_VALID,
  input  wire logic                 CMD_READY,
  output ddr3_cmd_pkg::cmd_t        CMD_OUT,
  output logic                      CMD_DROP,
  // status
  output logic [7:0]                BANK_OPEN,
  output logic                      PWR_DOWN,
  output logic                      SELF_REFRESH,
  output logic                      CLK_SUSPENDED,
  output logic                      BURST_INTERLEAVE,
  output logic [1:0]                ADDITIVE_LATENCY,
  // read launch
  output logic                      RD_BEAT,
  output logic [2:0]                RD_BEAT_ADDR
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  localparam int PW = 23;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_m_ff;
  logic [PW-1:0] pin_s_ff;
  assign pin_raw = {CK, CLOCK_COMPLEMENT, CKE, CS_N, RAS_N, CAS_N, WE_N,
                    BANK_SELECT, ROW_COL_ADDRESS};

  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          pin_m_ff[gi] <= 1'b0;
          pin_s_ff[gi] <= 1'b0;
        end else begin
          pin_m_ff[gi] <= pin_raw[gi];
          pin_s_ff[gi] <= pin_m_ff[gi];
        end
      end
    end
  endgenerate

  logic        ck_s;
  logic        ckc_s;
  logic        cke_s;
  logic        cs_n_s;
  logic        ras_n_s;
  logic        cas_n_s;
  logic        we_n_s;
  logic [2:0]  ba_s;
  logic [12:0] addr_s;
  assign {ck_s, ckc_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s,
          addr_s} = pin_s_ff;

  // ****************************************************************
  // clock crossing detect
  // ****************************************************************
  logic ck_prev_ff;
  logic rise;
  logic fall;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ck_prev_ff <= 1'b0;
    end else begin
      ck_prev_ff <= ck_s;
    end
  end
  assign rise = ck_s & ~ck_prev_ff & ~ckc_s;
  assign fall = ~ck_s & ck_prev_ff & ckc_s;

  // ****************************************************************
  // clock gate and power state
  // ****************************************************************
  logic                    cke_prev_ff;
  logic                    run;
  ddr3_cmd_pkg::pwr_state_t state_ff;
  ddr3_cmd_pkg::pwr_state_t nxt_state;
  ddr3_cmd_pkg::cmd_t       cmd;
  logic                    cmd_hit;

  assign run = cke_prev_ff & (state_ff == ddr3_cmd_pkg::ST_ACTIVE);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cke_prev_ff <= 1'b0;
    end else if (rise) begin
      cke_prev_ff <= cke_s;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ddr3_cmd_pkg::ST_ACTIVE: begin
        if (rise && cke_prev_ff && !cke_s && BANK_OPEN == 8'h00) begin
          if (cmd_hit && cmd.op == ddr3_cmd_pkg::OP_REF) begin
            nxt_state = ddr3_cmd_pkg::ST_SREF;
          end else begin
            nxt_state = ddr3_cmd_pkg::ST_PDOWN;
          end
        end
      end
      ddr3_cmd_pkg::ST_PDOWN, ddr3_cmd_pkg::ST_SREF: begin
        if (rise && cke_s) begin
          nxt_state = ddr3_cmd_pkg::ST_ACTIVE;
        end
      end
      default: nxt_state = ddr3_cmd_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff      <= ddr3_cmd_pkg::ST_ACTIVE;
      PWR_DOWN      <= 1'b0;
      SELF_REFRESH  <= 1'b0;
      CLK_SUSPENDED <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      PWR_DOWN      <= (nxt_state == ddr3_cmd_pkg::ST_PDOWN);
      SELF_REFRESH  <= (nxt_state == ddr3_cmd_pkg::ST_SREF);
      if (rise) begin
        CLK_SUSPENDED <= ~cke_s;
      end
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  always_comb begin
    cmd           = '0;
    cmd.op        = ddr3_cmd_pkg::OP_NOP;
    cmd.bank      = ba_s;
    cmd.row       = addr_s;
    cmd.col       = addr_s[`COL_MSB:0];
    cmd.auto_pre  = addr_s[`AP_BIT];
    cmd.all_banks = addr_s[`AP_BIT];
    cmd.chop      = ~addr_s[`CHOP_BIT];
    if (!cs_n_s) begin
      case ({ras_n_s, cas_n_s, we_n_s})
        3'b011:  cmd.op = ddr3_cmd_pkg::OP_ACT;
        3'b010:  cmd.op = ddr3_cmd_pkg::OP_PRE;
        3'b101:  cmd.op = ddr3_cmd_pkg::OP_RD;
        3'b100:  cmd.op = ddr3_cmd_pkg::OP_WR;
        3'b000:  cmd.op = ddr3_cmd_pkg::OP_MRS;
        3'b001:  cmd.op = ddr3_cmd_pkg::OP_REF;
        default: cmd.op = ddr3_cmd_pkg::OP_NOP;
      endcase
    end
  end
  assign cmd_hit = rise & run & (cmd.op != ddr3_cmd_pkg::OP_NOP);

  // ****************************************************************
  // mode registers
  // ****************************************************************
  logic [12:0] mr0_ff;
  logic [12:0] mr1_ff;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      mr0_ff <= `MR0_RST;
      mr1_ff <= `MR1_RST;
    end else if (cmd_hit && cmd.op == ddr3_cmd_pkg::OP_MRS) begin
      if (cmd.bank == 3'h0) begin
        mr0_ff <= cmd.row;
      end
      if (cmd.bank == 3'h1) begin
        mr1_ff <= cmd.row;
      end
    end
  end

  logic [1:0] bl_mode;
  logic [4:0] cl;
  logic [4:0] al;
  assign bl_mode = mr0_ff[`MR_BL_LSB +: 2];
  assign cl = `CL_BASE + {2'h0, mr0_ff[`MR_CL_LSB +: 3]};
  always_comb begin
    case (mr1_ff[`MR_AL_LSB +: 2])
      `AL_CL_M1: al = cl - 5'h01;
      `AL_CL_M2: al = cl - 5'h02;
      default:   al = 5'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      BURST_INTERLEAVE <= 1'b0;
      ADDITIVE_LATENCY <= 2'h0;
    end else begin
      BURST_INTERLEAVE <= mr0_ff[`MR_BT_BIT];
      ADDITIVE_LATENCY <= mr1_ff[`MR_AL_LSB +: 2];
    end
  end

  // ****************************************************************
  // burst engine
  // ****************************************************************
  logic       bst_wait_ff;
  logic       bst_run_ff;
  logic       bst_rd_ff;
  logic       bst_ap_ff;
  logic [2:0] bst_bank_ff;
  logic [2:0] bst_start_ff;
  logic [4:0] lat_ff;
  logic [3:0] beat_ff;
  logic [3:0] len_ff;
  logic       is_acc;
  logic       bst_end;
  logic [2:0] ord;

  assign is_acc = cmd_hit & (cmd.op == ddr3_cmd_pkg::OP_RD |
                             cmd.op == ddr3_cmd_pkg::OP_WR);
  assign bst_end = bst_run_ff & (rise | fall) & cke_prev_ff &
                   (beat_ff == len_ff - 4'h1);

  always_comb begin
    if (BURST_INTERLEAVE) begin
      ord = bst_start_ff ^ beat_ff[2:0];
    end else if (len_ff == `BEATS_BL4) begin
      ord = {bst_start_ff[2], bst_start_ff[1:0] + beat_ff[1:0]};
    end else begin
      ord = bst_start_ff + beat_ff[2:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bst_wait_ff  <= 1'b0;
      bst_run_ff   <= 1'b0;
      bst_rd_ff    <= 1'b0;
      bst_ap_ff    <= 1'b0;
      bst_bank_ff  <= 3'h0;
      bst_start_ff <= 3'h0;
      lat_ff       <= 5'h00;
      beat_ff      <= 4'h0;
      len_ff       <= `BEATS_BL8;
      RD_BEAT      <= 1'b0;
      RD_BEAT_ADDR <= 3'h0;
    end else begin
      RD_BEAT <= 1'b0;
      if (is_acc) begin
        bst_wait_ff  <= 1'b1;
        bst_run_ff   <= 1'b0;
        bst_rd_ff    <= (cmd.op == ddr3_cmd_pkg::OP_RD);
        bst_ap_ff    <= cmd.auto_pre;
        bst_bank_ff  <= cmd.bank;
        bst_start_ff <= cmd.col[2:0];
        lat_ff       <= al + cl;
        beat_ff      <= 4'h0;
        if (bl_mode == `BL_CHOP4 ||
            (bl_mode == `BL_OTF && cmd.chop)) begin
          len_ff <= `BEATS_BL4;
        end else begin
          len_ff <= `BEATS_BL8;
        end
      end else if (bst_wait_ff && rise && cke_prev_ff) begin
        if (lat_ff <= 5'h01) begin
          bst_wait_ff <= 1'b0;
          bst_run_ff  <= 1'b1;
        end
        lat_ff <= lat_ff - 5'h01;
      end else if (bst_run_ff && (rise || fall) && cke_prev_ff) begin
        RD_BEAT      <= bst_rd_ff;
        RD_BEAT_ADDR <= ord;
        beat_ff      <= beat_ff + 4'h1;
        if (bst_end) begin
          bst_run_ff <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // bank state
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      BANK_OPEN <= 8'h00;
    end else begin
      if (bst_end && bst_ap_ff) begin
        BANK_OPEN[bst_bank_ff] <= 1'b0;
      end
      if (cmd_hit && cmd.op == ddr3_cmd_pkg::OP_ACT) begin
        BANK_OPEN[cmd.bank] <= 1'b1;
      end else if (cmd_hit && cmd.op == ddr3_cmd_pkg::OP_PRE) begin
        if (cmd.all_banks) begin
          BANK_OPEN <= 8'h00;
        end else begin
          BANK_OPEN[cmd.bank] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // two-entry command buffer
  // ****************************************************************
  logic               skid_valid_ff;
  ddr3_cmd_pkg::cmd_t skid_ff;
  logic               push;
  assign push = cmd_hit & ~skid_valid_ff;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD_VALID     <= 1'b0;
      CMD_OUT       <= '0;
      skid_valid_ff <= 1'b0;
      skid_ff       <= '0;
      CMD_DROP      <= 1'b0;
    end else begin
      if (cmd_hit && skid_valid_ff && CMD_VALID && !CMD_READY) begin
        CMD_DROP <= 1'b1;
      end
      if (CMD_VALID && !CMD_READY) begin
        if (push) begin
          skid_valid_ff <= 1'b1;
          skid_ff       <= cmd;
        end
      end else if (skid_valid_ff) begin
        CMD_OUT       <= skid_ff;
        CMD_VALID     <= 1'b1;
        skid_valid_ff <= cmd_hit;
        skid_ff       <= cmd;
      end else begin
        CMD_OUT   <= cmd;
        CMD_VALID <= push;
      end
    end
  end

endmodule

// File: ddr3_cmd_port_monitor.sv
`timescale 1ns/1ps
module ddr3_cmd_port_monitor (
  // clock and reset
  input wire logic               CLK_SYS,
  input wire logic               ARST_N,
  // stream and status
  input wire logic               CMD_VALID,
  input wire logic               CMD_READY,
  input wire ddr3_cmd_pkg::cmd_t CMD_OUT,
  input wire logic               CMD_DROP,
  input wire logic [7:0]         BANK_OPEN,
  input wire logic               PWR_DOWN,
  input wire logic               SELF_REFRESH,
  input wire logic               CLK_SUSPENDED,
  input wire logic               RD_BEAT
);
  // ****
  // checks
  // ****
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence s_held;
    CMD_VALID && $stable(CMD_OUT);
  endsequence
  sequence s_quiet;
    !RD_BEAT [*3];
  endsequence
  a_hold_valid: assert property (
    CMD_VALID && !CMD_READY |=> s_held) else $error("stalled command lost");
  a_beat_gap: assert property (
    RD_BEAT |=> s_quiet) else $error("beats too close");
  a_no_beat_susp: assert property (
    CLK_SUSPENDED && $past(CLK_SUSPENDED) |-> !RD_BEAT)
    else $error("beat while suspended");
  a_lp_entry: assert property (
    $rose(PWR_DOWN || SELF_REFRESH) |-> CLK_SUSPENDED && BANK_OPEN == 8'h00)
    else $error("low power entry with open bank");
  a_pwr_excl: assert property (
    !(PWR_DOWN && SELF_REFRESH)) else $error("two low power modes");
  a_act_opens: assert property (
    $rose(CMD_VALID) && CMD_OUT.op == ddr3_cmd_pkg::OP_ACT
    |-> BANK_OPEN[CMD_OUT.bank]) else $error("activate left bank closed");
  a_pre_all: assert property (
    $rose(CMD_VALID) && CMD_OUT.op == ddr3_cmd_pkg::OP_PRE
    && CMD_OUT.all_banks |-> BANK_OPEN == 8'h00) else $error("bank left open");
  a_drop_sticky: assert property (
    $past(CMD_DROP) |-> CMD_DROP) else $error("drop flag cleared");
endmodule
bind ddr3_cmd_port ddr3_cmd_port_monitor u_mon (.CLK_SYS, .ARST_N,
  .CMD_VALID, .CMD_READY, .CMD_OUT, .CMD_DROP, .BANK_OPEN, .PWR_DOWN,
  .SELF_REFRESH, .CLK_SUSPENDED, .RD_BEAT);

// File: ddr3_ctl_model.sv
`timescale 1ns/1ps
module ddr3_ctl_model (
  // system clock
  input wire logic    clk,
  // link clock
  output logic        ck,
  output logic        ck_c,
  // command pins
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [12:0] addr
);
  // ****
  // free running link clock and command pins
  // ****
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    ba = 3'h0;
    addr = 13'h0000;
    ck = 1'b0;
    ck_c = 1'b1;
    #13;
    forever begin
      #160;
      ck = ~ck;
      ck_c = ~ck_c;
    end
  end
  task automatic cmd(input logic [4:0] c, input logic [2:0] b,
                     input logic [12:0] a);
    @(negedge ck);
    @(posedge clk);
    #1;
    {cke, cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(negedge ck);
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = {1'b1, ~c[2:0]};
    ba = ~b;
    addr = ~a;
  endtask
endmodule

// File: ddr3_cmd_port_test.sv
`timescale 1ns/1ps
module ddr3_cmd_port_test;
  // ****
  // bench signals
  // ****
  logic clk_sys, arst_n, cmd_ready, hold, ck, ck_c, cke;
  logic cs_n, ras_n, cas_n, we_n, cmd_valid, cmd_drop, pwr_down;
  logic self_ref, clk_susp, interleave, rd_beat;
  logic [2:0] ba, beat_addr, e_beat;
  logic [12:0] addr;
  logic [1:0] add_lat;
  logic [7:0] bank_open;
  ddr3_cmd_pkg::cmd_t cmd_out, e_cmd;
  ddr3_cmd_pkg::cmd_t exp_q[$];
  logic [2:0] beat_q[$];
  integer seed = 32'hd9a8cfb1;
  int error_cnt, n_checks, cyc;
  ddr3_ctl_model ctl (.clk(clk_sys), .ck(ck), .ck_c(ck_c), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr));
  ddr3_cmd_port dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .CK(ck),
    .CLOCK_COMPLEMENT(ck_c), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BANK_SELECT(ba), .ROW_COL_ADDRESS(addr),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OUT(cmd_out),
    .CMD_DROP(cmd_drop), .BANK_OPEN(bank_open), .PWR_DOWN(pwr_down),
    .SELF_REFRESH(self_ref), .CLK_SUSPENDED(clk_susp),
    .BURST_INTERLEAVE(interleave), .ADDITIVE_LATENCY(add_lat),
    .RD_BEAT(rd_beat), .RD_BEAT_ADDR(beat_addr));
  function automatic ddr3_cmd_pkg::cmd_t norm(ddr3_cmd_pkg::cmd_t x);
    if (x.op == ddr3_cmd_pkg::OP_ACT) {x.col, x.auto_pre, x.all_banks} = '0;
    if (x.op == ddr3_cmd_pkg::OP_ACT) x.chop = 1'b0;
    else x.row = '0;
    return x;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic [4:0] c, input logic [2:0] b,
                      input logic [12:0] a, input bit e);
    ddr3_cmd_pkg::cmd_t x;
    case (c[3:0])
      4'h3: x.op = ddr3_cmd_pkg::OP_ACT;
      4'h2: x.op = ddr3_cmd_pkg::OP_PRE;
      4'h5: x.op = ddr3_cmd_pkg::OP_RD;
      4'h4: x.op = ddr3_cmd_pkg::OP_WR;
      default: x.op = ddr3_cmd_pkg::OP_MRS;
    endcase
    {x.bank, x.row, x.col} = {b, a, a[9:0]};
    {x.auto_pre, x.all_banks, x.chop} = {a[10], a[10], ~a[12]};
    if (e) exp_q.push_back(norm(x));
    ctl.cmd(c, b, a);
  endtask
  task automatic burst(input logic [2:0] s, input int n, input bit il);
    for (int i = 0; i < n; i++)
      beat_q.push_back(il ? s ^ i[2:0] :
        n == 4 ? {s[2], s[1:0] + i[1:0]} : s + i[2:0]);
  endtask
  task automatic wait_ck(input int n);
    repeat (n) @(negedge ck);
    @(posedge clk_sys);
    #1;
  endtask
  // ****
  // clock, ready, scoreboard, timeout
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cmd_ready <= #1 !hold && ($random(seed) & 1);
  always @(posedge clk_sys) begin
    if (arst_n && cmd_valid && cmd_ready
        && cmd_out.op !== ddr3_cmd_pkg::OP_REF) begin
      e_cmd = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      check("command", norm(cmd_out), e_cmd);
    end
    if (arst_n && rd_beat) begin
      e_beat = beat_q.size() > 0 ? beat_q.pop_front() : 'x;
      check("beat", 32'(beat_addr), 32'(e_beat));
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    arst_n = 1'b0;
    hold = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    wait_ck(3);
    for (int i = 0; i < 3; i++) begin
      send(5'h10, 3'h1, 13'(i << 3), 1);
      check("add lat", 32'(add_lat), i);
    end
    send(5'h10, 3'h0, 13'h0001, 1);
    check("interleave", 32'(interleave), 0);
    for (int i = 0; i < 8; i++) send(5'h13, 3'(i), 13'($random(seed)), 1);
    check("open", 32'(bank_open), 32'hff);
    send(5'h1a, 3'h0, 13'h0000, 0);
    check("open", 32'(bank_open), 32'hff);
    send(5'h12, 3'h0, 13'h0000, 1);
    check("open", 32'(bank_open), 32'hfe);
    send(5'h12, 3'h3, 13'h0400, 1);
    check("open", 32'(bank_open), 0);
    send(5'h13, 3'h1, 13'h0abc, 1);
    send(5'h15, 3'h1, 13'h1403, 1);
    burst(3'h3, 8, 0);
    wait_ck(14);
    check("open", 32'(bank_open), 0);
    send(5'h10, 3'h0, 13'h0009, 1);
    check("interleave", 32'(interleave), 1);
    send(5'h13, 3'h2, 13'h0123, 1);
    send(5'h15, 3'h2, 13'h0005, 1);
    burst(3'h5, 4, 1);
    repeat (3) send(5'h07, 3'h0, 13'h0000, 0);
    check("suspend", 32'(clk_susp), 1);
    check("pdown", 32'(pwr_down), 0);
    send(5'h17, 3'h0, 13'h0000, 0);
    check("suspend", 32'(clk_susp), 0);
    wait_ck(12);
    check("open", 32'(bank_open), 32'h04);
    send(5'h14, 3'h2, 13'($random(seed)) & 13'h0bff, 1);
    send(5'h12, 3'h0, 13'h0400, 1);
    send(5'h07, 3'h0, 13'h0000, 0);
    check("pdown", 32'(pwr_down), 1);
    send(5'h03, 3'h3, 13'h0000, 0);
    check("open", 32'(bank_open), 0);
    send(5'h17, 3'h0, 13'h0000, 0);
    check("pdown", 32'(pwr_down), 0);
    send(5'h01, 3'h0, 13'h0000, 0);
    check("sref", 32'(self_ref), 1);
    send(5'h17, 3'h0, 13'h0000, 0);
    check("sref", 32'(self_ref), 0);
    send(5'h10, 3'h0, 13'h0002, 1);
    send(5'h13, 3'h4, 13'h0000, 1);
    send(5'h15, 3'h4, 13'h1406, 1);
    burst(3'h6, 4, 0);
    wait_ck(12);
    check("open", 32'(bank_open), 0);
    hold = 1'b1;
    for (int i = 5; i < 8; i++) send(5'h13, 3'(i), 13'h0042, i < 7);
    check("drop", 32'(cmd_drop), 1);
    hold = 1'b0;
    wait_ck(2);
    check("open", 32'(bank_open), 32'he0);
    check("left", exp_q.size() + beat_q.size(), 0);
    summarize();
  end
endmodule
